/* File: rtl/dpsnp_pkg.sv */
`default_nettype none
package dpsnp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ     = 200000;
  localparam int unsigned HPD_DEB_MS  = 100;
  localparam int unsigned HPD_DEB_CYC = HPD_DEB_MS * CLK_KHZ;
  localparam int unsigned DEB_W       = 25;

  // ----------------------------------------------------------------
  // aux transaction fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_NATIVE_WR   = 4'h8;
  localparam logic [3:0]  REPLY_NATIVE_ACK = 4'h0;
  localparam logic [19:0] ADDR_LANE_COUNT = 20'h00101;
  localparam logic [19:0] ADDR_SET_POWER  = 20'h00600;
  localparam int unsigned LANE_FIELD_MSB  = 4;
  localparam int unsigned PWR_FIELD_MSB   = 2;
  localparam logic [2:0]  PWR_CODE_D0     = 3'h1;
  localparam logic [2:0]  PWR_CODE_D3     = 3'h2;
  localparam logic [2:0]  PWR_CODE_D3_AUX = 3'h5;
  localparam logic [2:0]  HDR_BYTES       = 3'h4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] LANE_COUNT_RST = 5'h04;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRI_LOW  = 2'h0,
    TRI_OPEN = 2'h1,
    TRI_HIGH = 2'h2
  } dpsnp_tri_e;

  typedef enum logic [3:0] {
    ST_CHK  = 4'h1,
    ST_DEEP = 4'h2,
    ST_D3   = 4'h4,
    ST_D0   = 4'h8
  } dpsnp_state_e;

  // one decoded aux byte from the receive-only aux front end
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       valid;
    logic       from_sink;
    logic [7:0] data;
  } dpsnp_aux_s;

  // ternary pad: level seen with weak pull-up and with weak pull-down
  typedef struct packed {
    logic up_smp;
    logic dn_smp;
  } dpsnp_strap_s;

endpackage
`default_nettype wire

/* File: rtl/dpsnp_strap_dec.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsnp_strap_dec
  import dpsnp_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  input  wire dpsnp_pkg::dpsnp_strap_s pad_i,
  output var  dpsnp_pkg::dpsnp_tri_e   level_o
);
  import dpsnp_pkg::*;

  // a pin that follows the pull is floating, one that resists it is driven
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      level_o <= TRI_OPEN;
    else if (ce_i)
    begin
      if (pad_i.up_smp && pad_i.dn_smp)
        level_o <= TRI_HIGH;
      else if (!pad_i.up_smp && !pad_i.dn_smp)
        level_o <= TRI_LOW;
      else
        level_o <= TRI_OPEN;
    end
  end

endmodule // dpsnp_strap_dec
`default_nettype wire

/* File: rtl/dpsnp_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsnp_ctrl
  import dpsnp_pkg::*;
#(
  parameter int unsigned DEB_CYC = dpsnp_pkg::HPD_DEB_CYC
)
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    ce_i,
  input  wire dpsnp_pkg::dpsnp_aux_s   aux_i,
  input  wire logic                    hpd_i,
  input  wire logic                    hs_signal_i,
  input  wire logic                    lane_order_i,
  input  wire dpsnp_pkg::dpsnp_strap_s eq_select_a_i,
  input  wire dpsnp_pkg::dpsnp_strap_s eq_select_b_i,
  input  wire dpsnp_pkg::dpsnp_strap_s swing_linearity_select_i,
  input  wire dpsnp_pkg::dpsnp_strap_s flat_gain_select_a_i,
  input  wire dpsnp_pkg::dpsnp_strap_s flat_gain_select_b_i,
  output logic [3:0]                   lane_en_o,
  output logic                         hs_path_en_o,
  output logic                         deep_pwr_o,
  output logic                         pwr_d3_o,
  output logic [4:0]                   lane_count_o,
  output dpsnp_pkg::dpsnp_tri_e        eq_select_a_o,
  output dpsnp_pkg::dpsnp_tri_e        eq_select_b_o,
  output dpsnp_pkg::dpsnp_tri_e        swing_linearity_select_o,
  output logic [3:0]                   flat_gain_neg_o
);
  import dpsnp_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // straps
  // ----------------------------------------------------------------
  dpsnp_tri_e fg_a;
  dpsnp_tri_e fg_b;
  logic       lane_order_ff;

  dpsnp_strap_dec u_eq_a (.clk_i(ref_clk_i), .rst_n_i(rst_n), .ce_i(ce_i),
                          .pad_i(eq_select_a_i), .level_o(eq_select_a_o));
  dpsnp_strap_dec u_eq_b (.clk_i(ref_clk_i), .rst_n_i(rst_n), .ce_i(ce_i),
                          .pad_i(eq_select_b_i), .level_o(eq_select_b_o));
  dpsnp_strap_dec u_osl  (.clk_i(ref_clk_i), .rst_n_i(rst_n), .ce_i(ce_i),
                          .pad_i(swing_linearity_select_i),
                          .level_o(swing_linearity_select_o));
  dpsnp_strap_dec u_fg_a (.clk_i(ref_clk_i), .rst_n_i(rst_n), .ce_i(ce_i),
                          .pad_i(flat_gain_select_a_i), .level_o(fg_a));
  dpsnp_strap_dec u_fg_b (.clk_i(ref_clk_i), .rst_n_i(rst_n), .ce_i(ce_i),
                          .pad_i(flat_gain_select_b_i), .level_o(fg_b));

  // flat gain lookup, bit set means the lane runs at the low gain
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      flat_gain_neg_o <= 4'h0;
    else if (ce_i)
    begin
      case ({fg_b, fg_a})
        {TRI_LOW,  TRI_LOW }: flat_gain_neg_o <= 4'h0;
        {TRI_LOW,  TRI_OPEN}: flat_gain_neg_o <= 4'h1;
        {TRI_LOW,  TRI_HIGH}: flat_gain_neg_o <= 4'h2;
        {TRI_OPEN, TRI_LOW }: flat_gain_neg_o <= 4'h3;
        {TRI_OPEN, TRI_OPEN}: flat_gain_neg_o <= 4'h4;
        {TRI_OPEN, TRI_HIGH}: flat_gain_neg_o <= 4'h6;
        {TRI_HIGH, TRI_LOW }: flat_gain_neg_o <= 4'h8;
        {TRI_HIGH, TRI_OPEN}: flat_gain_neg_o <= 4'hc;
        {TRI_HIGH, TRI_HIGH}: flat_gain_neg_o <= 4'hf;
        default:              flat_gain_neg_o <= 4'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      lane_order_ff <= 1'b0;
    else if (ce_i)
      lane_order_ff <= lane_order_i;
  end

  // ----------------------------------------------------------------
  // aux snooper
  // ----------------------------------------------------------------
  // the aux front end is receive only, so snooping can never disturb the link
  logic [2:0]  byte_idx_ff;
  logic        wr_ff;
  logic [19:0] addr_ff;
  logic        lane_pend_ff;
  logic [4:0]  lane_val_ff;
  logic        pwr_pend_ff;
  logic        pwr_d0_val_ff;
  logic        req_data;
  logic        ack_seen;
  logic        lane_commit;
  logic        pwr_commit;

  assign req_data = aux_i.valid && !aux_i.from_sink && wr_ff && (byte_idx_ff == HDR_BYTES);
  assign ack_seen = aux_i.valid && aux_i.from_sink && (byte_idx_ff == 3'h0)
                    && (aux_i.data[7:4] == REPLY_NATIVE_ACK);
  // commit only on the sink acknowledge
  assign lane_commit = ce_i && ack_seen && lane_pend_ff;
  assign pwr_commit  = ce_i && ack_seen && pwr_pend_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_idx_ff <= 3'h0;
      wr_ff       <= 1'b0;
      addr_ff     <= 20'h0;
    end
    else if (ce_i)
    begin
      if (aux_i.start)
        byte_idx_ff <= 3'h0;
      else if (aux_i.valid)
      begin
        if (byte_idx_ff != HDR_BYTES)
          byte_idx_ff <= byte_idx_ff + 3'h1;
        if (!aux_i.from_sink)
        begin
          case (byte_idx_ff)
            3'h0:
            begin
              // i2c-over-aux and reads are not native writes
              wr_ff         <= (aux_i.data[7:4] == CMD_NATIVE_WR);
              addr_ff[19:16] <= aux_i.data[3:0];
            end
            3'h1:    addr_ff[15:8] <= aux_i.data;
            3'h2:    addr_ff[7:0]  <= aux_i.data;
            3'h4:    addr_ff       <= addr_ff + 20'h1;
            default: addr_ff       <= addr_ff;
          endcase
        end
      end
    end
  end

  // pending values die when a new request starts without an acknowledge
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lane_pend_ff  <= 1'b0;
      lane_val_ff   <= LANE_COUNT_RST;
      pwr_pend_ff   <= 1'b0;
      pwr_d0_val_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if ((aux_i.start && !aux_i.from_sink) || ack_seen)
      begin
        lane_pend_ff <= 1'b0;
        pwr_pend_ff  <= 1'b0;
      end
      else if (req_data)
      begin
        // only the two known fields are looked at
        if (addr_ff == ADDR_LANE_COUNT)
        begin
          // zero and other counts never become pending
          case (aux_i.data[LANE_FIELD_MSB:0])
            5'h01, 5'h02, 5'h04:
            begin
              lane_pend_ff <= 1'b1;
              lane_val_ff  <= aux_i.data[LANE_FIELD_MSB:0];
            end
            default: lane_pend_ff <= lane_pend_ff;
          endcase
        end
        if (addr_ff == ADDR_SET_POWER)
        begin
          case (aux_i.data[PWR_FIELD_MSB:0])
            PWR_CODE_D0:
            begin
              pwr_pend_ff   <= 1'b1;
              pwr_d0_val_ff <= 1'b1;
            end
            PWR_CODE_D3, PWR_CODE_D3_AUX:
            begin
              pwr_pend_ff   <= 1'b1;
              pwr_d0_val_ff <= 1'b0;
            end
            default: pwr_pend_ff <= pwr_pend_ff;
          endcase
        end
      end
    end
  end

  // the captured count only ever holds a legal value
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      lane_count_o <= LANE_COUNT_RST;
    else if (lane_commit)
      lane_count_o <= lane_val_ff;
  end

  // ----------------------------------------------------------------
  // hot-plug debounce
  // ----------------------------------------------------------------
  logic [DEB_W-1:0] deb_cnt_ff;
  logic             hpd_flt_ff;

  // rises pass at once, falls must last the whole debounce time
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deb_cnt_ff <= '0;
      hpd_flt_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (hpd_i)
      begin
        deb_cnt_ff <= '0;
        hpd_flt_ff <= 1'b1;
      end
      else if (hpd_flt_ff)
      begin
        if (deb_cnt_ff == DEB_W'(DEB_CYC - 1))
          hpd_flt_ff <= 1'b0;
        else
          deb_cnt_ff <= deb_cnt_ff + 1'b1;
      end
      else
        deb_cnt_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  dpsnp_state_e st_ff;
  dpsnp_state_e nxt_st;
  logic [3:0]   lane_mask;

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      // first decision uses the live pin level
      ST_CHK:  nxt_st = hpd_i ? ST_D3 : ST_DEEP;
      // leave deep saving when hot-plug is present
      ST_DEEP: nxt_st = hpd_flt_ff ? ST_D3 : ST_DEEP;
      // wake on a D0 write or on line activity
      ST_D3:   nxt_st = ((pwr_commit && pwr_d0_val_ff) || hs_signal_i) ? ST_D0 : ST_D3;
      ST_D0:   nxt_st = (pwr_commit && !pwr_d0_val_ff) ? ST_D3 : ST_D0;
      default: nxt_st = ST_CHK;
    endcase
    if (st_ff != ST_CHK && !hpd_flt_ff)
      nxt_st = ST_DEEP;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= ST_CHK;
    else if (ce_i)
      st_ff <= nxt_st;
  end

  // logical lanes from the count, then mirrored if reversed
  always_comb
  begin
    case (lane_count_o)
      5'h01:   lane_mask = 4'h1;
      5'h02:   lane_mask = 4'h3;
      default: lane_mask = 4'hf;
    endcase
    if (lane_order_ff)
      lane_mask = {lane_mask[0], lane_mask[1], lane_mask[2], lane_mask[3]};
  end

  // lanes and data path are live only in D0
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lane_en_o    <= 4'h0;
      hs_path_en_o <= 1'b0;
      deep_pwr_o   <= 1'b0;
      pwr_d3_o     <= 1'b1;
    end
    else if (ce_i)
    begin
      lane_en_o    <= (nxt_st == ST_D0) ? lane_mask : 4'h0;
      hs_path_en_o <= (nxt_st == ST_D0);
      deep_pwr_o   <= (nxt_st == ST_DEEP);
      pwr_d3_o     <= (nxt_st != ST_D0);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  a_lane_count_legal: assert property (
    lane_count_o inside {5'h01, 5'h02, 5'h04})
    else $error("captured lane count is not legal");

  a_lane_commit_only: assert property (
    !lane_commit |=> $stable(lane_count_o))
    else $error("lane count changed without acknowledged write");

  a_d3_path_off: assert property (
    (st_ff != ST_D0) && $past(ce_i) |-> !hs_path_en_o && (lane_en_o == 4'h0))
    else $error("data path active outside D0");

  a_d0_lane_cnt: assert property (
    (st_ff == ST_D0) && $past(ce_i) && $stable(lane_count_o)
      |-> ($countones(lane_en_o) == lane_count_o) && hs_path_en_o)
    else $error("enabled lanes differ from lane count");

  // with four lanes every lane is on, so only partial widths show the order
  a_lane_reverse: assert property (
    (st_ff == ST_D0) && $past(ce_i) && $stable(lane_count_o) && $stable(lane_order_ff)
      && (lane_count_o != 5'h04)
      |-> lane_en_o[3] == lane_order_ff && lane_en_o[0] == !lane_order_ff)
    else $error("lane order not applied");

  a_hpd_fall_wait: assert property (
    ce_i && $fell(hpd_flt_ff) |-> $past(deb_cnt_ff) == DEB_W'(DEB_CYC - 1))
    else $error("hot-plug fall accepted before debounce");

  a_deep_exit: assert property (
    ce_i && (st_ff == ST_DEEP) && hpd_flt_ff |=> st_ff == ST_D3)
    else $error("deep saving not left with hot-plug high");

  a_hpd_override: assert property (
    ce_i && (st_ff != ST_CHK) && !hpd_flt_ff |=> st_ff == ST_DEEP ##0 deep_pwr_o)
    else $error("hot-plug low did not force deep saving");

  a_reset_check: assert property (
    ce_i && (st_ff == ST_CHK) |=> (st_ff == ST_DEEP) == !$past(hpd_i))
    else $error("wrong state after reset check");

  a_wake_d0: assert property (
    ce_i && (st_ff == ST_D3) && hpd_flt_ff && pwr_commit && pwr_d0_val_ff
      |=> st_ff == ST_D0 ##0 hs_path_en_o)
    else $error("D0 write did not wake the data path");

  c_reach_d0:   cover property (st_ff == ST_D3 ##1 st_ff == ST_D0);
  c_enter_deep: cover property (st_ff == ST_D0 ##1 st_ff == ST_DEEP);
  c_two_rev:    cover property (st_ff == ST_D0 && lane_en_o == 4'hc);

endmodule // dpsnp_ctrl
`default_nettype wire

/* File: test/dpsnp_aux_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsnp_aux_model
  import dpsnp_pkg::*;
(
  input  wire logic                 clk_i,
  output var dpsnp_pkg::dpsnp_aux_s aux_o
);
  import dpsnp_pkg::*;

  // ----------------------------------------------------------------
  // byte driver
  // ----------------------------------------------------------------
  initial aux_o = '0;

  // a quiet line shows the inverse of the last byte, never a stale copy
  task automatic put(input logic st, input logic snk, input logic vld, input logic [7:0] d);
    @(posedge clk_i);
    aux_o <= '{start: st, stop: 1'b0, valid: vld, from_sink: snk, data: d};
  endtask

  task automatic idle();
    put(1'b0, 1'b0, 1'b0, ~aux_o.data);
  endtask

  // ----------------------------------------------------------------
  // one write request and the sink's reply
  // ----------------------------------------------------------------
  // source writes, sink replies
  task automatic write(input logic [3:0] cmd, input logic [19:0] adr, input logic [7:0] d,
                       input logic [3:0] rep, input int gap);
    put(1'b1, 1'b0, 1'b0, ~aux_o.data);
    put(1'b0, 1'b0, 1'b1, {cmd, adr[19:16]});
    put(1'b0, 1'b0, 1'b1, adr[15:8]);
    put(1'b0, 1'b0, 1'b1, adr[7:0]);
    put(1'b0, 1'b0, 1'b1, 8'h00);
    put(1'b0, 1'b0, 1'b1, d);
    // a slow sink leaves the line quiet before it answers
    repeat (gap) idle();
    put(1'b1, 1'b1, 1'b0, ~d);
    put(1'b0, 1'b1, 1'b1, {rep, 4'h0});
    idle();
  endtask
endmodule // dpsnp_aux_model
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dpsnp_pkg::*;

  // ----------------------------------------------------------------
  // clock, design and partner
  // ----------------------------------------------------------------
  logic         ref_clk_i    = 1'b0;
  logic         nrst_i       = 1'b0;
  logic         ce_i         = 1'b1;
  logic         hpd_i        = 1'b0;
  logic         hs_signal_i  = 1'b0;
  logic         lane_order_i = 1'b0;
  dpsnp_strap_s strap [5]    = '{default: 2'b10};
  dpsnp_aux_s   aux;
  logic [3:0]   lane_en;
  logic         hs_path;
  logic         deep;
  logic         d3;
  logic [4:0]   lane_cnt;
  dpsnp_tri_e   eq_a;
  dpsnp_tri_e   eq_b;
  dpsnp_tri_e   swing_lv;
  logic [3:0]   fg_neg;
  int           err_count = 0;
  int           checks    = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  // short debounce keeps the run small
  dpsnp_ctrl #(.DEB_CYC(50)) i_dpsnp_ctrl (
    .ref_clk_i                (ref_clk_i),
    .nrst_i                   (nrst_i),
    .ce_i                     (ce_i),
    .aux_i                    (aux),
    .hpd_i                    (hpd_i),
    .hs_signal_i              (hs_signal_i),
    .lane_order_i             (lane_order_i),
    .eq_select_a_i            (strap[0]),
    .eq_select_b_i            (strap[1]),
    .swing_linearity_select_i (strap[2]),
    .flat_gain_select_a_i     (strap[3]),
    .flat_gain_select_b_i     (strap[4]),
    .lane_en_o                (lane_en),
    .hs_path_en_o             (hs_path),
    .deep_pwr_o               (deep),
    .pwr_d3_o                 (d3),
    .lane_count_o             (lane_cnt),
    .eq_select_a_o            (eq_a),
    .eq_select_b_o            (eq_b),
    .swing_linearity_select_o (swing_lv),
    .flat_gain_neg_o          (fg_neg)
  );

  dpsnp_aux_model i_dpsnp_aux_model (
    .clk_i (ref_clk_i),
    .aux_o (aux)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // outputs are looked at on the falling edge, well after updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic pw(input logic [7:0] d);
    i_dpsnp_aux_model.write(CMD_NATIVE_WR, ADDR_SET_POWER, d, REPLY_NATIVE_ACK, 0);
    cyc(0);
  endtask

  function automatic logic [7:0] lanes(input int n, input logic rev);
    logic [3:0] m;
    m = 4'((1 << n) - 1);
    return rev ? {4'h0, m[0], m[1], m[2], m[3]} : {4'h0, m};
  endfunction

  function automatic dpsnp_strap_s lv(input int k);
    return (k == 0) ? 2'b00 : (k == 1) ? 2'b10 : 2'b11;
  endfunction

  // lane writes: command, address, data, reply, reply delay, count kept
  logic [3:0]  t_cmd [8] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h0, 4'h8, 4'h8};
  logic [19:0] t_adr [8] = '{20'h00101, 20'h00101, 20'h00101, 20'h00101,
                             20'h00101, 20'h00101, 20'h00102, 20'h00101};
  logic [7:0]  t_dat [8] = '{8'h81, 8'h00, 8'h04, 8'h03, 8'h02, 8'h02, 8'h02, 8'h02};
  logic [3:0]  t_rep [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0};
  int          t_gap [8] = '{0, 0, 3, 0, 0, 0, 0, 0};
  int          t_cnt [8] = '{1, 1, 4, 4, 4, 4, 4, 2};
  logic [7:0]  p_code [6] = '{8'h01, 8'h02, 8'h01, 8'h05, 8'h01, 8'h03};
  logic [7:0]  fg_tab [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0c, 8'h0f};

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    cyc(19);
    chk("pwr_d3 rst", d3, 8'h01);
    chk("lane_count rst", lane_cnt, 8'h04);
    chk("lane_en rst", lane_en, 8'h00);
    @(posedge ref_clk_i) nrst_i <= 1'b1;
    cyc(5);
    chk("deep after por", deep, 8'h01);
    @(posedge ref_clk_i) hpd_i <= 1'b1;
    cyc(3);
    chk("deep on hpd", deep, 8'h00);
    chk("d3 on hpd", d3, 8'h01);
    i_dpsnp_aux_model.write(CMD_NATIVE_WR, ADDR_LANE_COUNT, 8'h02, REPLY_NATIVE_ACK, 0);
    cyc(0);
    chk("count in d3", lane_cnt, 8'h02);
    chk("lanes in d3", lane_en, 8'h00);
    pw(8'h01);
    chk("hs path d0", hs_path, 8'h01);
    chk("lanes d0", lane_en, 8'h03);
    for (int r = 0; r < 2; r++)
    begin
      @(posedge ref_clk_i) lane_order_i <= r[0];
      cyc(3);
      for (int i = 0; i < 8; i++)
      begin
        i_dpsnp_aux_model.write(t_cmd[i], t_adr[i], t_dat[i], t_rep[i], t_gap[i]);
        cyc(0);
        chk("lane count", lane_cnt, 8'(t_cnt[i]));
        // enables follow the captured count one clock later
        cyc(1);
        chk("lane enables", lane_en, lanes(t_cnt[i], r[0]));
      end
    end
    @(posedge ref_clk_i) lane_order_i <= 1'b0;
    cyc(3);
    for (int i = 0; i < 6; i++)
    begin
      pw(p_code[i]);
      chk("hs path code", hs_path, {7'h0, i[0] == 1'b0 || i == 5});
      chk("lanes code", lane_en, (i[0] == 1'b0 || i == 5) ? 8'h03 : 8'h00);
    end
    @(posedge ref_clk_i) hpd_i <= 1'b0;
    cyc(20);
    @(posedge ref_clk_i) hpd_i <= 1'b1;
    cyc(60);
    chk("hs path irq", hs_path, 8'h01);
    pw(8'h02);
    @(posedge ref_clk_i) hs_signal_i <= 1'b1;
    cyc(2);
    chk("hs wake", hs_path, 8'h01);
    @(posedge ref_clk_i) hs_signal_i <= 1'b0;
    hpd_i <= 1'b0;
    cyc(40);
    chk("deep early", deep, 8'h00);
    cyc(20);
    chk("deep late", deep, 8'h01);
    chk("lanes deep", lane_en, 8'h00);
    pw(8'h01);
    chk("deep keeps", hs_path, 8'h00);
    chk("deep count", lane_cnt, 8'h02);
    @(posedge ref_clk_i) hpd_i <= 1'b1;
    cyc(3);
    chk("leave deep", deep, 8'h00);
    // clock enable low must freeze snooping and wake-up alike
    @(posedge ref_clk_i) ce_i <= 1'b0;
    i_dpsnp_aux_model.write(CMD_NATIVE_WR, ADDR_LANE_COUNT, 8'h01, REPLY_NATIVE_ACK, 0);
    @(posedge ref_clk_i) hs_signal_i <= 1'b1;
    cyc(2);
    chk("frozen path", hs_path, 8'h00);
    chk("frozen count", lane_cnt, 8'h02);
    @(posedge ref_clk_i) ce_i <= 1'b1;
    hs_signal_i <= 1'b0;
    cyc(1);
    chk("thawed path", hs_path, 8'h00);
    chk("thawed count", lane_cnt, 8'h02);
    for (int k = 0; k < 9; k++)
    begin
      @(posedge ref_clk_i);
      for (int j = 0; j < 3; j++)
        strap[j] <= lv(k % 3);
      strap[3] <= lv(k % 3);
      strap[4] <= lv(k / 3);
      cyc(4);
      chk("flat gain", fg_neg, fg_tab[k]);
      chk("eq a", eq_a, 8'(k % 3));
      chk("eq b", eq_b, 8'(k % 3));
      chk("swing", swing_lv, 8'(k % 3));
    end
    stop_test();
  end

  initial
  begin
    #50us;
    err_count++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
